// [common/task_file_pkg.sv]
/*
 * constants for the task file and buffer configuration register bank:
 * sub-cpu register indexes, host register indexes, field positions,
 * reset values, host modes, routes and refresh divider figures.
 * assumes a byte-wide sub-cpu register port and a byte-wide host port.
 */
package task_file_pkg;

	// ****************************************
	// sub-cpu register indexes (own choice)
	// ****************************************
	localparam logic [4:0] SUB_MEM_CFG      = 5'h10;
	localparam logic [4:0] SUB_IRQ_TRIGGER  = 5'h11;
	localparam logic [4:0] SUB_STATUS_OUT   = 5'h12;
	localparam logic [4:0] SUB_COMMAND_IN   = 5'h13;
	localparam logic [4:0] SUB_DRIVE_ADDR   = 5'h14;
	localparam logic [4:0] SUB_SECTOR_NUM   = 5'h15;
	localparam logic [4:0] SUB_DEV_CTRL_IN  = 5'h16;
	localparam logic [4:0] SUB_DRIVE_SELECT = 5'h17;
	localparam logic [4:0] SUB_INT_REASON   = 5'h18;
	localparam logic [4:0] SUB_FEATURES_IN  = 5'h19;
	localparam logic [4:0] SUB_ERROR_OUT    = 5'h1A;
	localparam logic [4:0] SUB_XFER_CTRL    = 5'h1B;

	// ****************************************
	// host task file register indexes
	// ****************************************
	localparam logic [2:0] HOST_ERR_FEAT    = 3'h1;
	localparam logic [2:0] HOST_REASON      = 3'h2;
	localparam logic [2:0] HOST_SECTOR      = 3'h3;
	localparam logic [2:0] HOST_DRIVE_SEL   = 3'h6;
	localparam logic [2:0] HOST_STAT_CMD    = 3'h7;
	localparam logic [2:0] HOST_CTRL_ADDR   = 3'h6;

	// ****************************************
	// fields and values
	// ****************************************
	localparam int         PRIO_HI          = 6;
	localparam int         PRIO_LO          = 5;
	localparam int         REFRESH_DIVIDER_SELECT_BIT        = 3;
	localparam int         WIDTH_BIT        = 2;
	localparam int         STATIC_BIT       = 1;
	localparam int         CACHE_BIT        = 0;
	localparam int         BSY_BIT          = 7;
	localparam int         SRST_BIT         = 2;
	localparam int         DRV_BIT          = 4;
	localparam int         OWN_DRV_BIT      = 3;
	localparam int         ROUTE_HI         = 2;
	localparam logic [7:0] STATUS_RESET     = 8'h80;
	localparam logic [7:0] XFER_CTRL_RESET  = 8'h08;
	localparam logic [7:0] DRIVE_SEL_ONES   = 8'hE0;
	localparam logic [7:0] DIAG_COMMAND     = 8'h90;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;

	// refresh divides sys_clk by these figures
	localparam int         REFRESH_DIV_SLOW = 400;
	localparam int         REFRESH_DIV_FAST = 200;
	localparam logic [8:0] REFRESH_LAST_SLOW = 9'(REFRESH_DIV_SLOW - 1);
	localparam logic [8:0] REFRESH_LAST_FAST = 9'(REFRESH_DIV_FAST - 1);

	typedef enum logic [2:0] {
		HMODE_COMPAT_A = 3'b000,
		HMODE_ATAPI    = 3'b001,
		HMODE_COMPAT_B = 3'b010,
		HMODE_UNKNOWN  = 3'b011
	} host_mode_t;

	typedef enum logic [2:0] {
		ROUTE_MEM_TO_HOST = 3'b000,
		ROUTE_HOST_TO_MEM = 3'b001,
		ROUTE_SUB_TO_MEM  = 3'b010,
		ROUTE_MEM_TO_SUB  = 3'b011,
		ROUTE_HOST_TO_SUB = 3'b100,
		ROUTE_SUB_TO_HOST = 3'b101,
		ROUTE_RESERVED    = 3'b110
	} route_t;

	typedef enum logic [1:0] {
		ARB_HOST  = 2'b00,
		ARB_OTHER = 2'b01
	} arb_state_t;

endpackage

// [dv/host_model.sv]
/*
 * host partner: task file read and write cycles toward the device.
 * assumes sys_clk from the bench; drives just after falling edges.
 */
`timescale 1ns/10ps
module host_model
	import task_file_pkg::*;
(
	input  wire logic       sys_clk,
	output logic            host_wr,
	output logic            host_rd,
	output logic            host_ctrl_sel,
	output logic      [2:0] host_addr,
	output logic      [7:0] host_wdata
);
	initial begin
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_ctrl_sel = 1'b0;
		host_addr = 3'h0;
		host_wdata = 8'h00;
	end
	// one strobe cycle, then the address and data lines show the inverse
	task automatic cyc(input logic w, input logic s, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge sys_clk);
		host_wr = w;
		host_rd = !w;
		host_ctrl_sel = s;
		host_addr = a;
		host_wdata = d;
		@(negedge sys_clk);
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
endmodule

// [dv/task_file_regs_bench.sv]
/*
 * bench for the task file register bank with host partner and
 * queued read checks. assumes the package and host_model.
 */
`timescale 1ns/10ps
module task_file_regs_bench;
	import task_file_pkg::*;
	logic sys_clk, rst, sub_wr, sub_rd, host_wr, host_rd, host_ctrl_sel;
	logic host_irq, command_arrival_irq, soft_reset_irq, refresh_tick;
	logic host_mem_req, other_mem_req, host_mem_grant, other_mem_grant;
	logic dram_nibble_wide, sram_select, cache_enable, sr_q, hr_q;
	logic [2:0] host_mode, host_addr, transfer_route_select;
	logic [4:0] sub_addr;
	logic [7:0] sub_wdata, sub_rdata, host_wdata, host_rdata, d;
	logic [7:0] sq[$], hq[$];
	logic [15:0] g;
	logic [31:0] lfsr = 32'h4BD7249D;
	int fail_count = 0;
	int checks = 0;

	task_file_regs u_task_file_regs (.*);
	host_model u_host_model (.*);

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sub(input logic w, input logic [4:0] a,
		input logic [7:0] v);
		@(negedge sys_clk);
		sub_wr = w;
		sub_rd = !w;
		sub_addr = a;
		sub_wdata = v;
		@(negedge sys_clk);
		sub_wr = 1'b0;
		sub_rd = 1'b0;
		sub_wdata = ~v;
	endtask
	task automatic srd(input logic [4:0] a, input logic [7:0] e);
		sq.push_back(e);
		sub(1'b0, a, 8'h00);
	endtask
	task automatic hrd(input logic s, input logic [2:0] a,
		input logic [7:0] e);
		hq.push_back(e);
		u_host_model.cyc(1'b0, s, a, 8'h00);
	endtask
	task automatic gap(output logic [15:0] n);
		n = 0;
		while (refresh_tick !== 1'b1 && n < 999) begin
			@(negedge sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (refresh_tick !== 1'b1 && n < 999);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		sr_q <= sub_rd;
		hr_q <= host_rd;
	end
	always @(negedge sys_clk) begin
		if (sr_q === 1'b1)
			check(16'(sub_rdata), 16'(sq.pop_front()));
		if (hr_q === 1'b1)
			check(16'(host_rdata), 16'(hq.pop_front()));
	end
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		#1000000;
		fail_count++;
		report_and_stop();
	end

	// ****
	// tests
	// ****
	initial begin
		rst = 1'b1;
		host_mode = HMODE_ATAPI;
		sub_wr = 1'b0;
		sub_rd = 1'b0;
		sub_addr = 5'h00;
		sub_wdata = 8'h00;
		host_mem_req = 1'b0;
		other_mem_req = 1'b0;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		srd(SUB_XFER_CTRL, XFER_CTRL_RESET);
		srd(SUB_DRIVE_SELECT, DRIVE_SEL_ONES);
		hrd(1'b0, HOST_STAT_CMD, STATUS_RESET);
		check(16'(cache_enable), 16'h1);
		sub(1'b1, SUB_IRQ_TRIGGER, rnd());
		check(16'(host_irq), 16'h0);
		u_host_model.cyc(1'b1, 1'b0, HOST_STAT_CMD, 8'hA0);
		check(16'(command_arrival_irq), 16'h0);
		$display("test reset and deselect done");
		u_host_model.cyc(1'b1, 1'b0, HOST_DRIVE_SEL, 8'h10);
		srd(SUB_DRIVE_SELECT, 8'hF0);
		sub(1'b1, SUB_STATUS_OUT, 8'h00);
		sub(1'b1, SUB_IRQ_TRIGGER, rnd());
		repeat (5) @(negedge sys_clk);
		check(16'(host_irq), 16'h1);
		hrd(1'b0, HOST_STAT_CMD, 8'h00);
		check(16'(host_irq), 16'h0);
		sub(1'b1, SUB_IRQ_TRIGGER, rnd());
		u_host_model.cyc(1'b1, 1'b0, HOST_STAT_CMD, 8'hA0);
		check(16'(host_irq), 16'h0);
		check(16'(command_arrival_irq), 16'h1);
		hrd(1'b0, HOST_STAT_CMD, STATUS_RESET);
		srd(SUB_COMMAND_IN, 8'hA0);
		check(16'(command_arrival_irq), 16'h0);
		$display("test selected command done");
		sub(1'b1, SUB_XFER_CTRL, 8'h00);
		sub(1'b1, SUB_STATUS_OUT, 8'h00);
		sub(1'b1, SUB_IRQ_TRIGGER, rnd());
		check(16'(host_irq), 16'h0);
		u_host_model.cyc(1'b1, 1'b0, HOST_STAT_CMD, DIAG_COMMAND);
		check(16'(command_arrival_irq), 16'h1);
		srd(SUB_COMMAND_IN, DIAG_COMMAND);
		for (int i = 0; i < 6; i++) begin
			sub(1'b1, SUB_XFER_CTRL, 8'(i) | XFER_CTRL_RESET);
			check(16'(transfer_route_select), 16'(i));
		end
		hrd(1'b0, HOST_STAT_CMD, STATUS_RESET);
		sub(1'b1, SUB_STATUS_OUT, 8'h00);
		u_host_model.cyc(1'b1, 1'b1, HOST_CTRL_ADDR, 8'h04);
		check(16'(soft_reset_irq), 16'h1);
		hrd(1'b0, HOST_STAT_CMD, STATUS_RESET);
		srd(SUB_DEV_CTRL_IN, 8'h04);
		check(16'(soft_reset_irq), 16'h0);
		$display("test diagnostic and soft reset done");
		d = rnd();
		u_host_model.cyc(1'b1, 1'b0, HOST_ERR_FEAT, d);
		sub(1'b1, SUB_FEATURES_IN, ~d);
		srd(SUB_FEATURES_IN, d);
		sub(1'b1, SUB_ERROR_OUT, ~d);
		hrd(1'b0, HOST_ERR_FEAT, ~d);
		sub(1'b1, SUB_DRIVE_ADDR, d);
		hrd(1'b1, HOST_CTRL_ADDR, d);
		sub(1'b1, SUB_SECTOR_NUM, ~d);
		srd(SUB_SECTOR_NUM, ~d);
		hrd(1'b0, HOST_SECTOR, ~d);
		sub(1'b1, SUB_INT_REASON, d);
		srd(SUB_INT_REASON, d);
		hrd(1'b0, HOST_REASON, d);
		srd(5'h05, ZERO_BYTE);
		$display("test task file done");
		for (int i = 0; i < 8; i++) begin
			d = (rnd() & 8'h60) | 8'(i);
			sub(1'b1, SUB_MEM_CFG, d);
			check(16'(dram_nibble_wide), 16'(d[WIDTH_BIT]));
			check(16'(sram_select), 16'(d[STATIC_BIT]));
			check(16'(cache_enable), 16'(!d[CACHE_BIT]));
			srd(SUB_MEM_CFG, d);
		end
		for (int i = 0; i < 2; i++) begin
			sub(1'b1, SUB_MEM_CFG, 8'(i) << REFRESH_DIVIDER_SELECT_BIT);
			gap(g);
			gap(g);
			check(g, i ? 16'(REFRESH_DIV_SLOW) : 16'(REFRESH_DIV_FAST));
		end
		$display("test memory config done");
		for (int p = 0; p < 4; p++) begin
			sub(1'b1, SUB_MEM_CFG, 8'(p) << PRIO_LO);
			host_mem_req = 1'b1;
			other_mem_req = 1'b1;
			g = 0;
			d = ZERO_BYTE;
			repeat ((p + 2) * 4) begin
				@(negedge sys_clk);
				g = g + 16'(host_mem_grant);
				d = d + 8'(other_mem_grant);
			end
			check(g, 16'((p + 1) * 4));
			check(16'(d), 16'h4);
		end
		host_mem_req = 1'b0;
		other_mem_req = 1'b0;
		$display("test priority done");
		for (int i = 0; i < 2; i++) begin
			host_mode = i ? HMODE_COMPAT_B : HMODE_COMPAT_A;
			sub(1'b1, SUB_XFER_CTRL, XFER_CTRL_RESET | (rnd() & 8'h03));
			sub(1'b1, SUB_IRQ_TRIGGER, rnd());
			check(16'(host_irq), 16'h0);
			u_host_model.cyc(1'b1, 1'b0, HOST_STAT_CMD, DIAG_COMMAND);
			check(16'(command_arrival_irq), 16'h0);
			srd(SUB_COMMAND_IN, ZERO_BYTE);
			hrd(1'b0, HOST_STAT_CMD, ZERO_BYTE);
		end
		$display("test compat modes done");
		repeat (3) @(negedge sys_clk);
		report_and_stop();
	end
endmodule

bind task_file_regs task_file_regs_props u_task_file_regs_props (.*);

// [dv/task_file_regs_props.sv]
/*
 * checker for the task file register bank, bound to its ports.
 * assumes the package and the single sys_clk domain.
 */
`timescale 1ns/10ps
module task_file_regs_props
	import task_file_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [2:0] host_mode,
	input wire logic       sub_wr,
	input wire logic       sub_rd,
	input wire logic [4:0] sub_addr,
	input wire logic [7:0] sub_wdata,
	input wire logic [7:0] sub_rdata,
	input wire logic       host_wr,
	input wire logic       host_rd,
	input wire logic       host_ctrl_sel,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic       host_irq,
	input wire logic       command_arrival_irq,
	input wire logic       soft_reset_irq,
	input wire logic       host_mem_req,
	input wire logic       other_mem_req,
	input wire logic       host_mem_grant,
	input wire logic       other_mem_grant,
	input wire logic       dram_nibble_wide,
	input wire logic       sram_select,
	input wire logic       cache_enable,
	input wire logic [2:0] transfer_route_select
);
	// ****
	// helpers
	// ****
	logic [7:0] wd_q;
	logic       trg;
	logic       atapi;
	logic       cmd_wr;
	logic       stat_rd;
	assign trg = sub_wr && sub_addr == SUB_IRQ_TRIGGER;
	assign atapi = host_mode == HMODE_ATAPI;
	assign cmd_wr = host_wr && !host_ctrl_sel && host_addr == HOST_STAT_CMD;
	assign stat_rd = host_rd && !host_ctrl_sel && host_addr == HOST_STAT_CMD;
	always_ff @(posedge sys_clk) begin
		wd_q <= sub_wdata;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_compat_trg;
		trg && !atapi && !host_rd && !host_wr |=> $stable(host_irq);
	endproperty
	a_compat_trg: assert property (p_compat_trg)
		else $error("host irq moved on compat trigger");
	property p_irq_clear;
		atapi && (stat_rd || cmd_wr) && !trg |=> !host_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("host irq not cleared");
	property p_irq_hold;
		host_irq && !host_rd && !host_wr |=> host_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("host irq dropped");
	property p_diag;
		cmd_wr && atapi && host_wdata == DIAG_COMMAND |=> command_arrival_irq;
	endproperty
	a_diag: assert property (p_diag)
		else $error("no command irq on diagnostic");
	property p_cmd_clear;
		sub_rd && sub_addr == SUB_COMMAND_IN && !host_wr
			|=> !command_arrival_irq;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear)
		else $error("command irq not cleared");
	property p_srst;
		host_wr && host_ctrl_sel && host_addr == HOST_CTRL_ADDR && atapi
			&& host_wdata[SRST_BIT] |=> soft_reset_irq;
	endproperty
	a_srst: assert property (p_srst)
		else $error("no soft reset irq");
	property p_srst_clear;
		sub_rd && sub_addr == SUB_DEV_CTRL_IN && !host_wr |=> !soft_reset_irq;
	endproperty
	a_srst_clear: assert property (p_srst_clear)
		else $error("soft reset irq not cleared");
	property p_grant;
		(host_mem_grant |-> host_mem_req && !other_mem_grant)
			and (other_mem_grant |-> other_mem_req);
	endproperty
	a_grant: assert property (p_grant)
		else $error("bad buffer grant");
	property p_cfg;
		sub_wr && sub_addr == SUB_MEM_CFG |=> dram_nibble_wide == wd_q[2]
			&& sram_select == wd_q[1] && cache_enable == !wd_q[0];
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("memory config outputs wrong");
	property p_route;
		sub_wr && sub_addr == SUB_XFER_CTRL
			|=> transfer_route_select == wd_q[2:0];
	endproperty
	a_route: assert property (p_route)
		else $error("route not taken");
	property p_drvsel;
		sub_rd && sub_addr == SUB_DRIVE_SELECT
			|=> sub_rdata[7:5] == 3'h7 && sub_rdata[3:0] == 4'h0;
	endproperty
	a_drvsel: assert property (p_drvsel)
		else $error("drive select fixed bits wrong");
endmodule

// [hw/task_file_regs.sv]
/*
 * sub-cpu side register bank: buffer memory configuration, refresh tick,
 * host access priority arbiter, and the atapi task file mirror with host
 * interrupt, command arrival and soft reset interrupts.
 * assumes sub-cpu and host accesses arrive as one-cycle strobes
 * synchronous to sys_clk; host_mode comes from the chip reset register.
 */
`timescale 1ns/10ps

module task_file_regs
	import task_file_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] host_mode,
	input  wire logic       sub_wr,
	input  wire logic       sub_rd,
	input  wire logic [4:0] sub_addr,
	input  wire logic [7:0] sub_wdata,
	output logic      [7:0] sub_rdata,
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic       host_ctrl_sel,
	input  wire logic [2:0] host_addr,
	input  wire logic [7:0] host_wdata,
	output logic      [7:0] host_rdata,
	output logic            host_irq,
	output logic            command_arrival_irq,
	output logic            soft_reset_irq,
	input  wire logic       host_mem_req,
	input  wire logic       other_mem_req,
	output logic            host_mem_grant,
	output logic            other_mem_grant,
	output logic            refresh_tick,
	output logic            dram_nibble_wide,
	output logic            sram_select,
	output logic            cache_enable,
	output logic      [2:0] transfer_route_select
);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] buffer_memory_config_r;
	logic [7:0] host_status_out_r;
	logic [7:0] host_command_in_r;
	logic [7:0] drive_address_out_r;
	logic [7:0] sector_number_r;
	logic [7:0] device_control_in_r;
	logic [7:0] drive_head_select_r;
	logic [7:0] interrupt_reason_r;
	logic [7:0] features_in_r;
	logic [7:0] error_out_r;
	logic [7:0] transfer_control_r;
	logic [8:0] refresh_cnt_r;
	logic [1:0] grant_cnt_r;
	arb_state_t arb_state_r;
	arb_state_t arb_state_nxt;

	logic       atapi_mode;
	logic       drive_selected;
	logic       sub_wr_cmd;
	logic       host_cmd_wr;
	logic       host_diag_wr;
	logic       cmd_accept;
	logic       srst_wr;
	logic       host_stat_rd;
	logic       refresh_last;
	logic [8:0] refresh_limit;

	function automatic logic sub_hit(input logic [4:0] idx);
		sub_hit = sub_addr == idx;
	endfunction

	function automatic logic host_hit(input logic ctl, input logic [2:0] idx);
		host_hit = (host_ctrl_sel == ctl) && (host_addr == idx);
	endfunction

	function automatic logic [7:0] drive_sel_bits(input logic [7:0] wd);
		drive_sel_bits          = DRIVE_SEL_ONES;
		drive_sel_bits[DRV_BIT] = wd[DRV_BIT];
	endfunction

	assign atapi_mode     = host_mode == HMODE_ATAPI;
	assign drive_selected = drive_head_select_r[DRV_BIT] ==
	                        transfer_control_r[OWN_DRV_BIT];
	assign host_cmd_wr    = atapi_mode && host_wr &&
	                        host_hit(1'b0, HOST_STAT_CMD);
	assign host_diag_wr   = host_cmd_wr && host_wdata == DIAG_COMMAND;
	assign cmd_accept     = host_cmd_wr &&
	                        (drive_selected || host_diag_wr);
	assign srst_wr        = atapi_mode && host_wr &&
	                        host_hit(1'b1, HOST_CTRL_ADDR) &&
	                        host_wdata[SRST_BIT];
	assign host_stat_rd   = atapi_mode && host_rd &&
	                        host_hit(1'b0, HOST_STAT_CMD);
	assign sub_wr_cmd     = sub_wr;

	// ****************************************
	// buffer memory configuration
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buffer_memory_config_r <= ZERO_BYTE;
		end else if (sub_wr_cmd && sub_hit(SUB_MEM_CFG)) begin
			buffer_memory_config_r <= sub_wdata;
		end
	end

	assign dram_nibble_wide = buffer_memory_config_r[WIDTH_BIT];
	assign sram_select      = buffer_memory_config_r[STATIC_BIT];
	assign cache_enable     = !buffer_memory_config_r[CACHE_BIT];

	// ****************************************
	// refresh divider
	// ****************************************
	assign refresh_limit = buffer_memory_config_r[REFRESH_DIVIDER_SELECT_BIT] ?
	                       REFRESH_LAST_SLOW : REFRESH_LAST_FAST;
	assign refresh_last  = refresh_cnt_r >= refresh_limit;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			refresh_cnt_r <= '0;
			refresh_tick  <= 1'b0;
		end else begin
			refresh_tick  <= refresh_last;
			refresh_cnt_r <= refresh_last ? '0 : refresh_cnt_r + 9'h1;
		end
	end

	// ****************************************
	// host access priority arbiter
	// ****************************************
	always_comb begin
		arb_state_nxt   = arb_state_r;
		host_mem_grant  = 1'b0;
		other_mem_grant = 1'b0;
		unique case (arb_state_r)
			ARB_HOST: begin
				if (host_mem_req) begin
					host_mem_grant = 1'b1;
					if (grant_cnt_r >=
					    buffer_memory_config_r[PRIO_HI:PRIO_LO] &&
					    other_mem_req) begin
						arb_state_nxt = ARB_OTHER;
					end
				end else begin
					other_mem_grant = other_mem_req;
				end
			end
			ARB_OTHER: begin
				other_mem_grant = other_mem_req;
				host_mem_grant  = !other_mem_req && host_mem_req;
				arb_state_nxt   = ARB_HOST;
			end
			default: begin
				arb_state_nxt = ARB_HOST;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arb_state_r <= ARB_HOST;
			grant_cnt_r <= '0;
		end else begin
			arb_state_r <= arb_state_nxt;
			if (arb_state_r == ARB_HOST && host_mem_grant &&
			    arb_state_nxt == ARB_HOST &&
			    grant_cnt_r < buffer_memory_config_r[PRIO_HI:PRIO_LO]) begin
				grant_cnt_r <= grant_cnt_r + 2'h1;
			end else if (!host_mem_grant || arb_state_nxt != ARB_HOST) begin
				grant_cnt_r <= '0;
			end
		end
	end

	// ****************************************
	// host status and command
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_status_out_r <= STATUS_RESET;
		end else if (cmd_accept || srst_wr) begin
			host_status_out_r[BSY_BIT] <= 1'b1;
		end else if (atapi_mode && sub_wr && sub_hit(SUB_STATUS_OUT)) begin
			host_status_out_r <= sub_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_command_in_r <= ZERO_BYTE;
		end else if (host_cmd_wr) begin
			host_command_in_r <= host_wdata;
		end
	end

	// ****************************************
	// task file mirrors
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drive_address_out_r <= ZERO_BYTE;
		end else if (sub_wr && sub_hit(SUB_DRIVE_ADDR)) begin
			drive_address_out_r <= sub_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			error_out_r <= ZERO_BYTE;
		end else if (sub_wr && sub_hit(SUB_ERROR_OUT)) begin
			error_out_r <= sub_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sector_number_r <= ZERO_BYTE;
		end else if (sub_wr && sub_hit(SUB_SECTOR_NUM)) begin
			sector_number_r <= sub_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			interrupt_reason_r <= ZERO_BYTE;
		end else if (sub_wr && sub_hit(SUB_INT_REASON)) begin
			interrupt_reason_r <= sub_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			device_control_in_r <= ZERO_BYTE;
		end else if (host_wr && host_hit(1'b1, HOST_CTRL_ADDR)) begin
			device_control_in_r <= host_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drive_head_select_r <= DRIVE_SEL_ONES;
		end else if (host_wr && host_hit(1'b0, HOST_DRIVE_SEL)) begin
			drive_head_select_r <= drive_sel_bits(host_wdata);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			features_in_r <= ZERO_BYTE;
		end else if (host_wr && host_hit(1'b0, HOST_ERR_FEAT)) begin
			features_in_r <= host_wdata;
		end
	end

	// ****************************************
	// transfer control
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			transfer_control_r <= XFER_CTRL_RESET;
		end else if (sub_wr && sub_hit(SUB_XFER_CTRL)) begin
			transfer_control_r <= sub_wdata;
		end
	end

	assign transfer_route_select = transfer_control_r[ROUTE_HI:0];

	// ****************************************
	// interrupts
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_irq <= 1'b0;
		end else if (atapi_mode && drive_selected && sub_wr &&
		             sub_hit(SUB_IRQ_TRIGGER)) begin
			host_irq <= 1'b1;
		end else if (host_stat_rd || host_cmd_wr) begin
			host_irq <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			command_arrival_irq <= 1'b0;
		end else if (cmd_accept) begin
			command_arrival_irq <= 1'b1;
		end else if (sub_rd && sub_hit(SUB_COMMAND_IN)) begin
			command_arrival_irq <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			soft_reset_irq <= 1'b0;
		end else if (srst_wr) begin
			soft_reset_irq <= 1'b1;
		end else if (sub_rd && sub_hit(SUB_DEV_CTRL_IN)) begin
			soft_reset_irq <= 1'b0;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sub_rdata <= ZERO_BYTE;
		end else if (sub_rd) begin
			unique case (sub_addr)
				SUB_MEM_CFG:      sub_rdata <= buffer_memory_config_r;
				SUB_COMMAND_IN:   sub_rdata <= atapi_mode ?
				                          host_command_in_r : ZERO_BYTE;
				SUB_SECTOR_NUM:   sub_rdata <= sector_number_r;
				SUB_DEV_CTRL_IN:  sub_rdata <= device_control_in_r;
				SUB_DRIVE_SELECT: sub_rdata <= drive_head_select_r;
				SUB_INT_REASON:   sub_rdata <= interrupt_reason_r;
				SUB_FEATURES_IN:  sub_rdata <= features_in_r;
				SUB_XFER_CTRL:    sub_rdata <= transfer_control_r;
				default:          sub_rdata <= ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_rdata <= ZERO_BYTE;
		end else if (host_rd) begin
			if (host_hit(1'b0, HOST_STAT_CMD)) begin
				host_rdata <= atapi_mode ? host_status_out_r : ZERO_BYTE;
			end else if (host_hit(1'b0, HOST_ERR_FEAT)) begin
				host_rdata <= error_out_r;
			end else if (host_hit(1'b0, HOST_REASON)) begin
				host_rdata <= interrupt_reason_r;
			end else if (host_hit(1'b0, HOST_SECTOR)) begin
				host_rdata <= sector_number_r;
			end else if (host_hit(1'b0, HOST_DRIVE_SEL)) begin
				host_rdata <= drive_head_select_r;
			end else if (host_hit(1'b1, HOST_CTRL_ADDR)) begin
				host_rdata <= drive_address_out_r;
			end else begin
				host_rdata <= ZERO_BYTE;
			end
		end
	end

endmodule
